// ---- hdl/flg_regs.svh ----
`ifndef FLG_REGS_SVH
`define FLG_REGS_SVH

// ==========================================================================
// Widths
// ==========================================================================
// Width of the pin port and of each window register.
`define FLG_PORT_W 16
// Width of the local bus data path.
`define FLG_BUS_W 32
// Width of the default base address.
`define FLG_ADDR_W 32

// ==========================================================================
// Register window byte offsets
// ==========================================================================
`define FLG_OFS_DIR 4'h0
`define FLG_OFS_DATA 4'h2
`define FLG_OFS_ENB 4'h4
`define FLG_OFS_CLR 4'h6
`define FLG_OFS_RSV8 4'h8
`define FLG_OFS_SET 4'hA
`define FLG_OFS_RSVC 4'hC
`define FLG_OFS_TOG 4'hE

// ==========================================================================
// Reset values
// ==========================================================================
`define FLG_RST_DIR 16'h0000
`define FLG_RST_DATA 16'h0000
`define FLG_RST_ENB 16'h0000
`define FLG_RST_RDATA 32'h0000_0000

// ==========================================================================
// Bus access size codes and the default window base
// ==========================================================================
`define FLG_SIZE_BYTE 2'h0
`define FLG_SIZE_WORD 2'h1
`define FLG_SIZE_LONG 2'h2
`define FLG_BASE_DEFAULT 32'h0000_0000

`endif

// ---- hdl/flg_pkg.sv ----
`include "flg_regs.svh"

package flg_pkg;

  // ========================================================================
  // Block state
  // ========================================================================
  // Every flip-flop of the port lives in this one record.
  typedef struct packed {
    logic [`FLG_PORT_W-1:0] dir;
    logic [`FLG_PORT_W-1:0] data;
    logic [`FLG_PORT_W-1:0] en;
    logic [`FLG_BUS_W-1:0] rdata;
    logic ack;
    logic seen;
  } flg_state_t;

endpackage

// ---- hdl/flg_pin_bank.sv ----
`timescale 1ns/10ps

`include "flg_regs.svh"

module flg_pin_bank
  import flg_pkg::*;
(
  input wire logic [`FLG_PORT_W-1:0] dir,
  input wire logic [`FLG_PORT_W-1:0] en,
  input wire logic [`FLG_PORT_W-1:0] data,
  input wire logic [`FLG_PORT_W-1:0] pins_i,
  output logic [`FLG_PORT_W-1:0] pins_o,
  output logic [`FLG_PORT_W-1:0] pins_oe,
  output logic [`FLG_PORT_W-1:0] pins_rd
);

  // ========================================================================
  // Per-pin drive and read selection
  // ========================================================================
  // An enabled output pin is driven from stored data; an enabled input pin
  // reads its level. Disabled pins read back stored data.
  for (genvar i = 0; i < `FLG_PORT_W; i++)
  begin : g_pin
    assign pins_o[i] = data[i];
    assign pins_oe[i] = en[i] & dir[i];
    assign pins_rd[i] = (en[i] & ~dir[i]) ? pins_i[i] : data[i];
  end

endmodule

// ---- hdl/flg_top.sv ----
`timescale 1ns/10ps

`include "flg_regs.svh"

module flg_top
  import flg_pkg::*;
#(
  parameter logic [`FLG_ADDR_W-1:0] BASE_ADDR = `FLG_BASE_DEFAULT
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_req,
  input wire logic bus_wr,
  input wire logic [`FLG_ADDR_W-1:0] bus_addr,
  input wire logic [1:0] bus_size,
  input wire logic [`FLG_BUS_W-1:0] bus_wdata,
  output logic [`FLG_BUS_W-1:0] bus_rdata,
  output logic bus_ack,
  output logic bus_ready,
  input wire logic [`FLG_PORT_W-1:0] fast_port_pins_i,
  output logic [`FLG_PORT_W-1:0] fast_port_pins_o,
  output logic [`FLG_PORT_W-1:0] fast_port_pins_oe
);

  // ========================================================================
  // Declarations
  // ========================================================================
  flg_state_t st_q;
  flg_state_t st_d;
  logic hit;
  logic [3:0] lanes;
  logic [3:0] ofs_hi;
  logic [3:0] ofs_lo;
  logic [`FLG_PORT_W-1:0] pins_rd;
  logic [`FLG_PORT_W-1:0] in_mask;

  // ========================================================================
  // Helper functions
  // ========================================================================
  // Byte lanes of a big-endian longword; bit 3 is bus bits 31:24.
  function automatic logic [3:0] lane_mask(input logic [1:0] a, input logic [1:0] sz);
    logic [3:0] m;
    m = 4'hF;
    if (sz == `FLG_SIZE_BYTE)
    begin
      m = 4'h8 >> a;
    end
    else if (sz == `FLG_SIZE_WORD)
    begin
      m = a[1] ? 4'h3 : 4'hC;
    end
    return m;
  endfunction

  // Applies one halfword of a store to the register at a window offset.
  function automatic flg_state_t apply_write(
    input flg_state_t s,
    input logic [3:0] ofs,
    input logic [1:0] be,
    input logic [`FLG_PORT_W-1:0] wd
  );
    flg_state_t r;
    logic [`FLG_PORT_W-1:0] m;
    r = s;
    m = {{8{be[1]}}, {8{be[0]}}};
    if (ofs == `FLG_OFS_DIR)
    begin
      r.dir = (s.dir & ~m) | (wd & m);
    end
    else if (ofs == `FLG_OFS_DATA)
    begin
      r.data = (s.data & ~m) | (wd & m);
    end
    else if (ofs == `FLG_OFS_ENB)
    begin
      r.en = (s.en & ~m) | (wd & m);
    end
    else if (ofs == `FLG_OFS_CLR)
    begin
      r.data = s.data & (wd | ~m);
    end
    else if (ofs == `FLG_OFS_SET)
    begin
      r.data = s.data | (wd & m);
    end
    else if (ofs == `FLG_OFS_TOG)
    begin
      r.data = s.data ^ (wd & m);
    end
    // Offsets 0x8 and 0xC fall through and leave every register alone.
    return r;
  endfunction

  // Read view of one halfword offset of the window.
  function automatic logic [`FLG_PORT_W-1:0] read_view(
    input logic [3:0] ofs,
    input flg_state_t s,
    input logic [`FLG_PORT_W-1:0] pin_view
  );
    logic [`FLG_PORT_W-1:0] v;
    v = s.dir;
    if (ofs == `FLG_OFS_ENB)
    begin
      v = s.en;
    end
    else if (ofs[1])
    begin
      v = pin_view;
    end
    return v;
  endfunction

  // ========================================================================
  // Address decode
  // ========================================================================
  // Only the upper address bits pick the window; no privilege input exists.
  assign hit = bus_req && (bus_addr[`FLG_ADDR_W-1:4] == BASE_ADDR[`FLG_ADDR_W-1:4]);
  assign lanes = lane_mask(bus_addr[1:0], bus_size);
  assign ofs_hi = {bus_addr[3:2], 2'h0};
  assign ofs_lo = {bus_addr[3:2], 2'h2};
  assign in_mask = st_q.en & ~st_q.dir;

  // ========================================================================
  // Pin drive and sampling
  // ========================================================================
  flg_pin_bank u_pins (
    .dir(st_q.dir),
    .en(st_q.en),
    .data(st_q.data),
    .pins_i(fast_port_pins_i),
    .pins_o(fast_port_pins_o),
    .pins_oe(fast_port_pins_oe),
    .pins_rd(pins_rd)
  );

  // ========================================================================
  // Next state
  // ========================================================================
  // A taken access is answered in the same data-phase edge: stores update
  // the registers and loads capture the pins and registers into rdata.
  always_comb
  begin
    st_d = st_q;
    st_d.seen = 1'b1;
    st_d.ack = hit;
    if (hit && bus_wr)
    begin
      st_d = apply_write(st_d, ofs_hi, lanes[3:2], bus_wdata[31:16]);
      st_d = apply_write(st_d, ofs_lo, lanes[1:0], bus_wdata[15:0]);
    end
    else if (hit)
    begin
      st_d.rdata = {read_view(ofs_hi, st_q, pins_rd), read_view(ofs_lo, st_q, pins_rd)};
    end
  end

  // ========================================================================
  // State register
  // ========================================================================
  // Reset clears the stored data at once, so the pins drop without a clock.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.dir <= `FLG_RST_DIR;
      st_q.data <= `FLG_RST_DATA;
      st_q.en <= `FLG_RST_ENB;
      st_q.rdata <= `FLG_RST_RDATA;
      st_q.ack <= 1'b0;
      st_q.seen <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Bus outputs
  // ========================================================================
  // The port never inserts wait states.
  assign bus_ready = 1'b1;
  assign bus_ack = st_q.ack;
  assign bus_rdata = st_q.rdata;

  // ========================================================================
  // Checks
  // ========================================================================
  // Bus timing, address decode, reset, register update and read view properties.
  AST_ACK_NEXT: assert property (
    @(posedge clock) disable iff (!rst_n)
    hit |=> bus_ack ##1 !bus_ack || $past(hit))
    else $error("Access not answered in exactly one cycle.");

  AST_NO_ACK_MISS: assert property (
    @(posedge clock) disable iff (!rst_n)
    (bus_req && bus_addr[`FLG_ADDR_W-1:4] != BASE_ADDR[`FLG_ADDR_W-1:4]) |=> !bus_ack)
    else $error("Access outside the window was answered.");

  AST_RESET_CLEAR: assert property (
    @(posedge clock) disable iff (!rst_n)
    !st_q.seen |-> (st_q.dir == `FLG_RST_DIR && st_q.data == `FLG_RST_DATA &&
                 st_q.en == `FLG_RST_ENB && fast_port_pins_oe == '0))
    else $error("Registers not cleared after reset.");

  AST_DIR_DRIVES_OE: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && bus_wr && bus_size == `FLG_SIZE_WORD && bus_addr[3:0] == `FLG_OFS_DIR)
    |=> fast_port_pins_oe == ($past(bus_wdata[31:16]) & st_q.en))
    else $error("Direction store did not steer output enables.");

  AST_DATA_DRIVES_PINS: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && bus_wr && bus_size == `FLG_SIZE_WORD && bus_addr[3:0] == `FLG_OFS_DATA)
    |=> fast_port_pins_o == $past(bus_wdata[15:0]))
    else $error("Data store did not reach the pins.");

  AST_CLEAR_ALIAS: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && bus_wr && bus_size == `FLG_SIZE_WORD && bus_addr[3:0] == `FLG_OFS_CLR)
    |=> st_q.data == ($past(st_q.data) & $past(bus_wdata[15:0])))
    else $error("Clear alias gave the wrong data.");

  AST_SET_ALIAS: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && bus_wr && bus_size == `FLG_SIZE_WORD && bus_addr[3:0] == `FLG_OFS_SET)
    |=> st_q.data == ($past(st_q.data) | $past(bus_wdata[15:0])))
    else $error("Set alias gave the wrong data.");

  AST_TOGGLE_ALIAS: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && bus_wr && bus_size == `FLG_SIZE_WORD && bus_addr[3:0] == `FLG_OFS_TOG)
    |=> st_q.data == ($past(st_q.data) ^ $past(bus_wdata[15:0])))
    else $error("Toggle alias gave the wrong data.");

  AST_RESERVED_STORE: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && bus_wr && bus_size == `FLG_SIZE_WORD &&
     (bus_addr[3:0] == `FLG_OFS_RSV8 || bus_addr[3:0] == `FLG_OFS_RSVC))
    |=> $stable(st_q.dir) && $stable(st_q.data) && $stable(st_q.en) && bus_ack)
    else $error("Store to an unused field changed a register.");

  AST_READ_PINS: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && !bus_wr && bus_size == `FLG_SIZE_WORD && bus_addr[3:0] == `FLG_OFS_DATA)
    |=> bus_rdata[15:0] == (($past(fast_port_pins_i) & $past(in_mask)) |
                            ($past(st_q.data) & ~$past(in_mask))))
    else $error("Data read did not return sampled pins.");

  AST_READ_DIR_ALIAS: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && !bus_wr && bus_size == `FLG_SIZE_LONG && bus_addr[3:0] == `FLG_OFS_RSVC)
    |=> bus_rdata == {$past(st_q.dir), $past(pins_rd)})
    else $error("Read view at 0xC is wrong.");

  AST_BYTE_LANE: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && bus_wr && bus_size == `FLG_SIZE_BYTE && bus_addr[3:0] == `FLG_OFS_DIR)
    |=> st_q.dir == {$past(bus_wdata[31:24]), $past(st_q.dir[7:0])})
    else $error("Byte store touched the wrong byte.");

  AST_LONG_PAIR: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && bus_wr && bus_size == `FLG_SIZE_LONG && bus_addr[3:0] == `FLG_OFS_DIR)
    |=> st_q.dir == $past(bus_wdata[31:16]) && st_q.data == $past(bus_wdata[15:0]))
    else $error("Longword store did not cover both registers.");

  AST_ENABLE_STORE: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && bus_wr && bus_size == `FLG_SIZE_WORD && bus_addr[3:0] == `FLG_OFS_ENB)
    |=> st_q.en == $past(bus_wdata[31:16]))
    else $error("Enable store did not land.");

  AST_READ_ENABLE: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && !bus_wr && bus_size == `FLG_SIZE_LONG && bus_addr[3:0] == `FLG_OFS_ENB)
    |=> bus_rdata[31:16] == $past(st_q.en))
    else $error("Read view at 0x4 is wrong.");

  AST_LOAD_NO_EFFECT: assert property (
    @(posedge clock) disable iff (!rst_n)
    (hit && !bus_wr) |=> $stable(st_q.dir) && $stable(st_q.data) && $stable(st_q.en))
    else $error("Load changed a register.");

endmodule

// ---- dv/flg_cpu_model.sv ----
`timescale 1ns/10ps

// ==========================================================================
// Local bus master model
// ==========================================================================
// Stands in for the processor core: one request per data-phase cycle.
module flg_cpu_model
(
  input wire logic clock,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ack,
  output logic bus_req,
  output logic bus_wr,
  output logic [31:0] bus_addr,
  output logic [1:0] bus_size,
  output logic [31:0] bus_wdata
);
  // Idle lines at time zero.
  initial
  begin
    bus_req = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 32'h0;
    bus_size = 2'h0;
    bus_wdata = 32'h0;
  end

  // Presents a request for one cycle, then takes the answer in the next.
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [1:0] sz,
                      input logic [31:0] wd, output logic [31:0] rd, output logic ack);
    @(negedge clock);
    bus_req = 1'b1;
    bus_wr = wr;
    bus_addr = addr;
    bus_size = sz;
    bus_wdata = wd;
    @(negedge clock);
    // Released write, address and data lines show the inverse so a stale value cannot pass as live; bus_size keeps its value.
    bus_req = 1'b0;
    bus_wr = ~wr;
    bus_addr = ~addr;
    bus_wdata = ~wd;
    ack = bus_ack;
    rd = bus_rdata;
  endtask
endmodule

// ---- dv/flg_top_tb_top.sv ----
`timescale 1ns/10ps

`include "flg_regs.svh"

// ==========================================================================
// Testbench top
// ==========================================================================
module flg_top_tb_top;
  localparam logic [31:0] BASE = 32'h0040_0010;
  logic clock;
  logic rst_n;
  logic bus_req;
  logic bus_wr;
  logic [31:0] bus_addr;
  logic [1:0] bus_size;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic bus_ack;
  logic bus_ready;
  logic [15:0] pins_i;
  logic [15:0] pins_o;
  logic [15:0] pins_oe;
  logic [31:0] rd;
  logic ack;
  int bad_count = 0;
  int cmp_count = 0;

  flg_top #(.BASE_ADDR(BASE)) u_flg_top (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_ready(bus_ready), .fast_port_pins_i(pins_i),
    .fast_port_pins_o(pins_o), .fast_port_pins_oe(pins_oe));

  flg_cpu_model u_flg_cpu_model (.clock(clock), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_size(bus_size),
    .bus_wdata(bus_wdata));

  // Free-running 100 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compares one value and counts the outcome.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask

  // Store inside the window; every hit must be acknowledged.
  task automatic wr(input logic [3:0] ofs, input logic [1:0] sz, input logic [31:0] wd);
    u_flg_cpu_model.xfer(1'b1, BASE + {28'h0, ofs}, sz, wd, rd, ack);
    check("store ack", {31'h0, ack}, 32'h1);
    check("store ready", {31'h0, bus_ready}, 32'h1);
  endtask

  // Load inside the window and compare the masked data.
  task automatic rdc(input logic [3:0] ofs, input logic [31:0] mask, input logic [31:0] exp);
    u_flg_cpu_model.xfer(1'b0, BASE + {28'h0, ofs}, `FLG_SIZE_LONG, 32'h0, rd, ack);
    check("load ack", {31'h0, ack}, 32'h1);
    check("load data", rd & mask, exp);
  endtask

  // Compares the pin drive levels and enables.
  task automatic pins(input logic [15:0] o, input logic [15:0] oe);
    check("pins out", {16'h0, pins_o}, {16'h0, o});
    check("pins enable", {16'h0, pins_oe}, {16'h0, oe});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    #20000;
    bad_count++;
    conclude();
  end

  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    pins_i = 16'h3C00;
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    pins(16'h0000, 16'h0000);
    rdc(4'h0, 32'hFFFF_0000, 32'h0);
    rdc(4'h4, 32'hFFFF_0000, 32'h0);
    wr(4'h0, `FLG_SIZE_LONG, 32'h00FF_A5C3);
    wr(4'h4, `FLG_SIZE_WORD, 32'hFFFF_0000);
    pins(16'hA5C3, 16'h00FF);
    // Upper byte is input and reads the pins, lower byte reads stored data.
    rdc(4'h0, 32'hFFFF_FFFF, 32'h00FF_3CC3);
    rdc(4'h4, 32'hFFFF_FFFF, 32'hFFFF_3CC3);
    rdc(4'h8, 32'hFFFF_FFFF, 32'h00FF_3CC3);
    rdc(4'hC, 32'hFFFF_FFFF, 32'h00FF_3CC3);
    wr(4'h6, `FLG_SIZE_WORD, 32'h0000_FF0F);
    pins(16'hA503, 16'h00FF);
    wr(4'hA, `FLG_SIZE_WORD, 32'h0000_0030);
    pins(16'hA533, 16'h00FF);
    wr(4'hE, `FLG_SIZE_WORD, 32'h0000_0101);
    pins(16'hA432, 16'h00FF);
    wr(4'h8, `FLG_SIZE_LONG, 32'hFFFF_0000);
    wr(4'hC, `FLG_SIZE_WORD, 32'hFFFF_0000);
    rdc(4'h0, 32'hFFFF_FFFF, 32'h00FF_3C32);
    wr(4'h0, `FLG_SIZE_BYTE, 32'hAB00_0000);
    wr(4'h3, `FLG_SIZE_BYTE, 32'h0000_005A);
    pins(16'hA45A, 16'hABFF);
    u_flg_cpu_model.xfer(1'b1, BASE ^ 32'h0000_0100, `FLG_SIZE_LONG, 32'h0, rd, ack);
    check("miss ack", {31'h0, ack}, 32'h0);
    pins(16'hA45A, 16'hABFF);
    wr(4'h2, `FLG_SIZE_WORD, 32'h0000_1234);
    wr(4'h0, `FLG_SIZE_WORD, 32'h0F0F_0000);
    pins(16'h1234, 16'h0F0F);
    // Word loads at the data offset sample the input pins afresh at each load.
    u_flg_cpu_model.xfer(1'b0, BASE + 32'h2, `FLG_SIZE_WORD, 32'h0, rd, ack);
    check("word load", rd, 32'h0F0F_3204);
    pins_i = 16'hC300;
    u_flg_cpu_model.xfer(1'b0, BASE + 32'h2, `FLG_SIZE_WORD, 32'h0, rd, ack);
    check("word load", rd, 32'h0F0F_C204);
    check("word load ack", {31'h0, ack}, 32'h1);
    @(negedge clock);
    rst_n = 1'b0;
    #1;
    pins(16'h0000, 16'h0000);
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    rdc(4'h0, 32'hFFFF_0000, 32'h0);
    conclude();
  end
endmodule
